// [design/pe_consts.svh]
`ifndef PE_CONSTS_SVH
`define PE_CONSTS_SVH

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define PE_SR1_BUSY 0
`define PE_SR1_WEL 1
`define PE_SR1_ERS 5
`define PE_SR1_PGM 6
`define PE_SR2_ERS_OK 2

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define PE_BUF_DEPTH 512
`define PE_BUF_AW 9
`define PE_CLK_PERIOD_NS 10
`define PE_ADDR3 3'h3
`define PE_ADDR4 3'h4
`define PE_BYTE_ERASED 8'hff

`endif

// [design/pe_pkg.sv]
package pe_pkg;
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } pe_phase_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_RUN = 3'b010,
    S_EVAL = 3'b011,
    S_ERR = 3'b100
  } pe_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PROG = 3'b001,
    OP_OTP = 3'b010,
    OP_SECT = 3'b011,
    OP_CHIP = 3'b100,
    OP_EVAL = 3'b101,
    OP_WREN = 3'b110,
    OP_CLR = 3'b111
  } pe_op_t;
endpackage

// [design/pe_seq.sv]
`timescale 1ns/1ps
`include "pe_consts.svh"
// Contract
// RL1: Program or erase runs only while the write enable latch is 1.
// RL2: Write enable latch clears automatically when program or erase finishes.
// RL3: Busy flag is 1 throughout a self-timed operation, 0 afterwards.
// RL4: Ready/busy pin is low while an operation runs, high after.
// RL5: Any program failure sets the program error flag.
// RL6: Program to a protected sector is not executed and flags program error.
// RL7: Out-of-range address: busy stays 1 and the matching error flag sets.
// RL8: Internal operation starts only once chip select returns high.
// RL9: Multi-pass allowed: reprogramming an ECC unit disables its ECC.
// RL10: Multi-pass disabled: reprogramming an ECC unit fails with program error.
// RL11: Page is 256 or 512 bytes, selected by config, page aligned.
// RL12: Excess data wraps from page end to byte zero of same page.
// RL13: Short loads program only sent bytes; others in page untouched.
// RL14: Host keeps secure region address bits 31 to 10 at zero.
// RL15: Host starts secure region writes word aligned, ends on word boundary.
// RL16: Zeros into a locked secure region fail with program error.
// RL17: Secure region bits sent as 1 stay untouched.
// RL18: Sector erase sets all bits of the addressed sector to one.
// RL19: Erase of a protected sector is skipped and flags erase error.
// RL20: Whole-array erase runs only with all protect bits zero, else silent.
// RL21: Erase evaluation sets erase-ok status from sector state, busy meanwhile.
// RL22: Erase evaluation needs no write enable, never flags failure.
// RL23: Write enable command sets the write enable latch.
// RL24: Clear-flags command resets both error flags, even while busy.
// RL25: Busy stays 1 while an error flag remains set.
// RL26: Command opcodes are parameters.
module pe_seq
  import pe_pkg::*;
#(
  parameter logic [7:0] WREN_OP = 8'h01, CLR_OP = 8'h02, // RL26
  parameter logic [7:0] PROG_A_OP = 8'h10, PROG_B_OP = 8'h11, PROG_C_OP = 8'h12,
  parameter logic [7:0] PROG_D_OP = 8'h13, OTP_OP = 8'h14, SECT_A_OP = 8'h20,
  parameter logic [7:0] SECT_B_OP = 8'h21, CHIP_OP = 8'h22, EVAL_OP = 8'h23,
  parameter logic [31:0] ARRAY_BYTES = 32'h0200_0000,
  parameter int EES_TIME_NS = 20000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io,
  input wire logic page512,
  input wire logic multipass_disable,
  input wire logic [2:0] block_protect,
  input wire logic otp_locked,
  input wire logic sector_protected,
  input wire logic array_done,
  input wire logic array_fail,
  input wire logic unit_reprogrammed,
  input wire logic sector_erased,
  input wire logic [8:0] buf_index,
  output logic busy_flag,
  output logic write_enable_latch,
  output logic program_error_flag,
  output logic erase_error_flag,
  output logic [7:0] status_one_volatile,
  output logic [7:0] status_two_volatile,
  output logic ready_busy_pin_n,
  output logic [31:0] target_addr,
  output logic prog_start,
  output logic otp_start,
  output logic erase_start,
  output logic chip_erase_start,
  output logic prog_abort,
  output logic ecc_unit_disable,
  output logic [7:0] buf_byte,
  output logic buf_loaded
);
  localparam int EES_RAW = EES_TIME_NS / `PE_CLK_PERIOD_NS;
  localparam int EES_CYC = (EES_RAW < 1) ? 1 : EES_RAW;

  function automatic pe_op_t decode(input logic [7:0] c);
    if (c == WREN_OP) return OP_WREN;
    if (c == CLR_OP) return OP_CLR;
    if (c == PROG_A_OP || c == PROG_B_OP || c == PROG_C_OP || c == PROG_D_OP) return OP_PROG;
    if (c == OTP_OP) return OP_OTP;
    if (c == SECT_A_OP || c == SECT_B_OP) return OP_SECT;
    if (c == CHIP_OP) return OP_CHIP;
    if (c == EVAL_OP) return OP_EVAL;
    return OP_NONE;
  endfunction

  function automatic logic [2:0] addr_len(input logic [7:0] c);
    if (c == PROG_A_OP || c == PROG_C_OP || c == SECT_A_OP) return `PE_ADDR3;
    if (c == PROG_B_OP || c == PROG_D_OP || c == SECT_B_OP) return `PE_ADDR4;
    if (c == OTP_OP || c == EVAL_OP) return `PE_ADDR4;
    return 3'h0;
  endfunction

  // ----------------------------------------
  // Link side, on the serial clock
  // ----------------------------------------
  logic [1:0] pg_sync, bz_sync;
  pe_phase_t phase, next_phase;
  logic [2:0] bitpos;
  logic [2:0] abytes;
  logic [7:0] shift;
  logic [7:0] opcode;
  logic [31:0] addr;
  logic [8:0] ptr;
  logic addr_done, data_seen, any_zero;
  logic [7:0] buf_mem [0:`PE_BUF_DEPTH-1];
  logic [`PE_BUF_DEPTH-1:0] loaded;

  wire lk_quad = (phase == PH_DATA) && (opcode == PROG_C_OP || opcode == PROG_D_OP);
  wire [3:0] bsum = {1'b0, bitpos} + (lk_quad ? 4'h4 : 4'h1);
  wire byte_done = bsum[3];
  wire [7:0] in_byte = lk_quad ? {shift[3:0], io} : {shift[6:0], io[0]};
  wire [31:0] shifted_addr = {addr[23:0], in_byte};
  wire addr_last = (phase == PH_ADDR) && ((abytes + 3'h1) == addr_len(opcode));
  wire has_data = (decode(opcode) == OP_PROG) || (decode(opcode) == OP_OTP);
  // Wrap inside the selected page; bit 8 is kept for 256-byte pages
  wire [8:0] wrap_ptr = pg_sync[1] ? ptr + 9'h001 : {ptr[8], ptr[7:0] + 8'h01}; // RL11 RL12
  // No loading while an operation owns the buffer
  wire wr_byte = (phase == PH_DATA) && byte_done && !bz_sync[1];

  always_ff @(posedge sck) begin
    pg_sync <= {pg_sync[0], page512};
    bz_sync <= {bz_sync[0], busy_flag};
  end

  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_CMD: next_phase = (addr_len(in_byte) == 3'h0) ? PH_SKIP : PH_ADDR;
      PH_ADDR: begin
        if (addr_last) begin
          next_phase = has_data ? PH_DATA : PH_SKIP;
        end
      end
      PH_DATA: next_phase = PH_DATA;
      PH_SKIP: next_phase = PH_SKIP;
    endcase
  end

  // Frame counters restart whenever chip select is high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      phase <= PH_CMD;
      bitpos <= 3'h0;
      abytes <= 3'h0;
    end else begin
      bitpos <= bsum[2:0];
      if (byte_done) begin
        phase <= next_phase;
        abytes <= (phase == PH_ADDR) ? abytes + 3'h1 : 3'h0;
      end
    end
  end

  always_ff @(posedge sck) begin
    shift <= in_byte;
    if (byte_done && phase == PH_CMD) begin
      opcode <= in_byte;
      addr <= 32'h0000_0000;
      addr_done <= (addr_len(in_byte) == 3'h0);
      data_seen <= 1'b0;
      any_zero <= 1'b0;
      loaded <= '0;
    end
    if (byte_done && phase == PH_ADDR) begin
      addr <= shifted_addr;
      ptr <= shifted_addr[8:0];
      addr_done <= addr_last;
    end
    if (wr_byte) begin
      buf_mem[ptr] <= in_byte; // RL12
      loaded[ptr] <= 1'b1; // RL13
      ptr <= wrap_ptr;
      data_seen <= 1'b1;
      any_zero <= any_zero | (in_byte != `PE_BYTE_ERASED); // RL16 RL17
    end
  end

  // ----------------------------------------
  // Core side, on clk
  // ----------------------------------------
  logic [2:0] cs_q;
  pe_state_t state, next_state;
  pe_op_t op, next_op;
  logic [31:0] tmr, next_tmr, next_addr;
  logic ers_ok, next_ers_ok, next_wel, set_pgm, set_ers;
  logic next_prog, next_otp, next_erase, next_chip, next_abort, next_eccdis;

  // Link registers are read only after the frame, when they stand still
  wire frame_end = cs_q[1] & ~cs_q[2]; // RL8
  wire pe_op_t fe_op = decode(opcode);
  wire clr = frame_end && (fe_op == OP_CLR); // RL24
  wire oor = (target_addr >= ARRAY_BYTES);
  wire prog_kind = (op == OP_PROG) || (op == OP_OTP);
  wire reprog_fail = unit_reprogrammed && multipass_disable && prog_kind;
  wire is_pe = (fe_op == OP_PROG) || (fe_op == OP_OTP) || (fe_op == OP_SECT) || (fe_op == OP_CHIP);
  wire data_ok = data_seen || !((fe_op == OP_PROG) || (fe_op == OP_OTP));
  wire next_pgm = set_pgm | (program_error_flag & ~clr);
  wire next_ers = set_ers | (erase_error_flag & ~clr);
  wire next_busy = (next_state != S_IDLE);
  // Verdicts of the check cycle
  wire chk_prog_bad = (op == OP_PROG) && (oor || sector_protected); // RL6 RL7
  wire chk_otp_bad = (op == OP_OTP) && otp_locked && any_zero; // RL16
  wire chk_sect_bad = (op == OP_SECT) && (oor || sector_protected); // RL7 RL19
  wire chk_chip_skip = (op == OP_CHIP) && (block_protect != 3'b000); // RL20

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = target_addr;
    next_tmr = tmr;
    next_wel = write_enable_latch;
    next_ers_ok = ers_ok;
    set_pgm = 1'b0;
    set_ers = 1'b0;
    next_prog = 1'b0;
    next_otp = 1'b0;
    next_erase = 1'b0;
    next_chip = 1'b0;
    next_abort = 1'b0;
    next_eccdis = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (frame_end && fe_op == OP_WREN) begin
          next_wel = 1'b1; // RL23
        end
        if (frame_end && fe_op == OP_EVAL && addr_done) begin
          next_state = S_EVAL; // RL22
          next_tmr = 32'(EES_CYC - 1);
          next_addr = addr;
        end
        if (frame_end && is_pe && write_enable_latch && addr_done && data_ok) begin
          next_state = S_CHECK; // RL1
          next_op = fe_op;
          next_addr = addr;
        end
      end
      S_CHECK: begin
        set_pgm = chk_prog_bad || chk_otp_bad; // RL5
        set_ers = chk_sect_bad;
        next_prog = (op == OP_PROG) && !chk_prog_bad;
        next_otp = (op == OP_OTP) && !chk_otp_bad;
        next_erase = (op == OP_SECT) && !chk_sect_bad; // RL18
        next_chip = (op == OP_CHIP) && !chk_chip_skip;
        if (set_pgm || set_ers) begin
          next_state = S_ERR; // RL25
          next_wel = 1'b0;
        end else if (next_prog || next_otp || next_erase || next_chip) begin
          next_state = S_RUN;
        end else begin
          next_state = S_IDLE; // RL20
        end
      end
      S_RUN: begin
        if (array_fail || reprog_fail) begin
          set_pgm = prog_kind; // RL5 RL10
          set_ers = !prog_kind;
          next_abort = reprog_fail;
          next_state = S_ERR;
          next_wel = 1'b0;
        end else begin
          next_eccdis = unit_reprogrammed && prog_kind; // RL9
          if (array_done) begin
            next_state = S_IDLE; // RL3
            next_wel = 1'b0; // RL2
          end
        end
      end
      S_EVAL: begin
        if (tmr == 32'h0000_0000) begin
          next_ers_ok = sector_erased; // RL21
          next_state = S_IDLE;
        end else begin
          next_tmr = tmr - 32'h0000_0001;
        end
      end
      S_ERR: begin
        if (clr) begin
          next_state = S_IDLE; // RL25
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_q <= 3'b111;
    end else begin
      cs_q <= {cs_q[1:0], cs_n};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      op <= OP_NONE;
      tmr <= 32'h0000_0000;
      target_addr <= 32'h0000_0000;
      write_enable_latch <= 1'b0;
      program_error_flag <= 1'b0;
      erase_error_flag <= 1'b0;
      ers_ok <= 1'b0;
      busy_flag <= 1'b0;
      ready_busy_pin_n <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      tmr <= next_tmr;
      target_addr <= next_addr;
      write_enable_latch <= next_wel;
      program_error_flag <= next_pgm;
      erase_error_flag <= next_ers;
      ers_ok <= next_ers_ok;
      busy_flag <= next_busy; // RL3
      ready_busy_pin_n <= ~next_busy; // RL4
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_start <= 1'b0;
      otp_start <= 1'b0;
      erase_start <= 1'b0;
      chip_erase_start <= 1'b0;
      prog_abort <= 1'b0;
      ecc_unit_disable <= 1'b0;
    end else begin
      prog_start <= next_prog;
      otp_start <= next_otp;
      erase_start <= next_erase;
      chip_erase_start <= next_chip;
      prog_abort <= next_abort;
      ecc_unit_disable <= next_eccdis;
    end
  end

  // Array fetches page data; stable because loading stops while busy
  always_ff @(posedge clk) begin
    buf_byte <= buf_mem[buf_index];
    buf_loaded <= loaded[buf_index];
  end

  always_comb begin
    status_one_volatile = 8'h00;
    status_one_volatile[`PE_SR1_BUSY] = busy_flag;
    status_one_volatile[`PE_SR1_WEL] = write_enable_latch;
    status_one_volatile[`PE_SR1_ERS] = erase_error_flag;
    status_one_volatile[`PE_SR1_PGM] = program_error_flag;
    status_two_volatile = 8'h00;
    status_two_volatile[`PE_SR2_ERS_OK] = ers_ok;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pin_busy: assert property (@(posedge clk) disable iff (rst) // RL4
    ready_busy_pin_n != busy_flag) else $error("ready pin disagrees with busy");
  a_start_wel: assert property (@(posedge clk) disable iff (rst) // RL1
    (prog_start || erase_start) |-> $past(write_enable_latch, 2) && busy_flag)
    else $error("operation started without write enable");
  a_start_cs: assert property (@(posedge clk) disable iff (rst) // RL8
    (prog_start || otp_start || erase_start || chip_erase_start) |-> cs_q[1])
    else $error("operation started inside a frame");
  a_done_clear: assert property (@(posedge clk) disable iff (rst) // RL2
    (state == S_RUN && array_done && !array_fail && !reprog_fail)
    |=> !write_enable_latch && !busy_flag) else $error("finish left latch or busy");
  a_range_err: assert property (@(posedge clk) disable iff (rst) // RL7
    (state == S_CHECK && op == OP_PROG && oor) |=> program_error_flag && busy_flag
    && !prog_start) else $error("out of range program not flagged");
  a_prot_ers: assert property (@(posedge clk) disable iff (rst) // RL19
    (state == S_CHECK && op == OP_SECT && sector_protected)
    |=> erase_error_flag && !erase_start) else $error("protected erase not flagged");
  a_chip_skip: assert property (@(posedge clk) disable iff (rst) // RL20
    (state == S_CHECK && op == OP_CHIP && block_protect != 3'b000)
    |=> !busy_flag && !erase_error_flag && !chip_erase_start)
    else $error("protected chip erase not skipped");
  a_mpd_fail: assert property (@(posedge clk) disable iff (rst) // RL10
    (state == S_RUN && reprog_fail && !clr) |=> program_error_flag && prog_abort)
    else $error("reprogrammed unit not failed");
  a_mp_ecc: assert property (@(posedge clk) disable iff (rst) // RL9
    (state == S_RUN && unit_reprogrammed && !multipass_disable && prog_kind && !array_fail)
    |=> ecc_unit_disable && !program_error_flag) else $error("ecc not disabled");
  a_err_hold: assert property (@(posedge clk) disable iff (rst) // RL25
    (program_error_flag || erase_error_flag) && !clr |=> busy_flag)
    else $error("busy dropped while error set");
  a_clear_ok: assert property (@(posedge clk) disable iff (rst) // RL24
    (clr && !set_pgm && !set_ers) |=> !program_error_flag && !erase_error_flag)
    else $error("clear did not reset flags");
  a_wren_set: assert property (@(posedge clk) disable iff (rst) // RL23
    (state == S_IDLE && frame_end && fe_op == OP_WREN) |=> write_enable_latch)
    else $error("write enable not latched");
  a_eval_busy: assert property (@(posedge clk) disable iff (rst) // RL21
    (state == S_IDLE && next_state == S_EVAL) |=> busy_flag[*8])
    else $error("evaluation busy too short");
endmodule // pe_seq

// [tb/pe_host_model.sv]
`timescale 1ns/1ps
module pe_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] io
);
  // --------
  // Serial host, mode 0, clock only inside frames
  // --------
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io = 4'h0;
  end
  task automatic clk4(input logic [3:0] v);
    io = v;
    #15 sck = 1'b1;
    #15 sck = 1'b0;
  endtask
  task automatic byte1(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk4({{3{~b[i]}}, b[i]});
  endtask
  task automatic xfer(input logic [7:0] op, input logic [31:0] a, input int na, input int nd,
                      input logic [7:0] d0, input bit q);
    logic [7:0] d;
    cs_n = 1'b0;
    #15;
    byte1(op);
    for (int i = na - 1; i >= 0; i--) byte1(a[8*i +: 8]);
    for (int i = 0; i < nd; i++) begin
      // All-ones fill keeps every byte at ff
      d = (d0 == 8'hff) ? d0 : d0 + 8'(i);
      if (q) begin
        clk4(d[7:4]);
        clk4(d[3:0]);
      end else begin
        byte1(d);
      end
    end
    #15 cs_n = 1'b1;
    io = ~io;
  endtask
endmodule // pe_host_model

// [tb/spi_flash_program_erase_sequencer_tb.sv]
`timescale 1ns/1ps
module spi_flash_program_erase_sequencer_tb;
  // --------
  // Signals
  // --------
  localparam logic [7:0] WR = 8'h01, CL = 8'h02, PA = 8'h10, PB = 8'h11, PC = 8'h12;
  localparam logic [7:0] PD = 8'h13, OT = 8'h14, SA = 8'h20, SB = 8'h21, CH = 8'h22;
  localparam logic [7:0] EV = 8'h23;
  localparam logic [31:0] ABYT = 32'h0001_0000;
  logic clk = 1'b0, rst = 1'b1, page512 = 1'b0, multipass_disable = 1'b0, otp_locked = 1'b0;
  logic sector_protected = 1'b0, array_done = 1'b0, array_fail = 1'b0, sector_erased = 1'b0;
  logic unit_reprogrammed = 1'b0, sclr = 1'b0;
  logic [2:0] block_protect = 3'h0;
  logic [8:0] buf_index = 9'h000;
  logic sck, cs_n, busy_flag, write_enable_latch, program_error_flag, erase_error_flag;
  logic ready_busy_pin_n, prog_start, otp_start, erase_start, chip_erase_start, prog_abort;
  logic ecc_unit_disable, buf_loaded;
  logic [3:0] io;
  logic [7:0] status_one_volatile, status_two_volatile, buf_byte;
  logic [31:0] target_addr;
  logic [5:0] seen = 6'h00;
  int num_errors = 0, check_count = 0;

  pe_seq #(.ARRAY_BYTES(ABYT), .EES_TIME_NS(200)) pe_seq_inst (
    .clk, .rst, .sck, .cs_n, .io, .page512, .multipass_disable, .block_protect, .otp_locked,
    .sector_protected, .array_done, .array_fail, .unit_reprogrammed, .sector_erased,
    .buf_index, .busy_flag, .write_enable_latch, .program_error_flag, .erase_error_flag,
    .status_one_volatile, .status_two_volatile, .ready_busy_pin_n, .target_addr, .prog_start,
    .otp_start, .erase_start, .chip_erase_start, .prog_abort, .ecc_unit_disable, .buf_byte,
    .buf_loaded
  );
  pe_host_model pe_host_model_inst (.sck, .cs_n, .io);

  always #5 clk = ~clk;
  // Sticky record of start, abort and ECC-disable pulses since the last frame began
  always @(posedge clk) begin
    if (sclr) begin
      seen <= 6'h00;
    end else begin
      seen <= seen | {prog_start, otp_start, erase_start, chip_erase_start, prog_abort,
                      ecc_unit_disable};
    end
  end

  // --------
  // Shared tasks
  // --------
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frm(input logic [7:0] op, input logic [31:0] a = 0, input int na = 0,
                     input int nd = 0, input logic [7:0] d0 = 8'h00, input bit q = 1'b0);
    sclr <= 1'b1;
    cyc(1);
    sclr <= 1'b0;
    pe_host_model_inst.xfer(op, a, na, nd, d0, q);
    cyc(8);
  endtask
  task automatic wren;
    frm(WR);
    ck(status_one_volatile[1], 1'b1);
  endtask
  task automatic clr;
    frm(CL);
    ck(status_one_volatile, 8'h00);
  endtask
  task automatic fin(input logic f);
    @(posedge clk);
    array_done <= ~f;
    array_fail <= f;
    @(posedge clk);
    array_done <= 1'b0;
    array_fail <= 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [8:0] i, input logic [7:0] b, input logic l);
    buf_index <= i;
    cyc(2);
    if (l) ck(buf_byte, b);
    ck(buf_loaded, l);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic s_nowel;
    frm(PA, 32'h0, 3, 1);
    frm(SA, 32'h0, 3);
    ck(busy_flag, 1'b0);
    ck(seen, 6'h00);
  endtask
  task automatic s_prog(input logic [7:0] op, input int na, input bit q, input logic p,
                        input logic [8:0] a);
    logic [8:0] w;
    w = p ? 9'h000 : {a[8], 8'h00};
    page512 <= p;
    wren();
    frm(op, {23'h0, a}, na, 3, 8'h5a, q);
    ck(status_one_volatile, 8'h03);
    ck(ready_busy_pin_n, 1'b0);
    ck(seen[5], 1'b1);
    ck(target_addr, {23'h0, a});
    rd(a, 8'h5a, 1'b1);
    rd(a + 9'h001, 8'h5b, 1'b1);
    rd(w, 8'h5c, 1'b1);
    rd(w + 9'h001, 8'h00, 1'b0);
    fin(1'b0);
    ck(status_one_volatile, 8'h00);
    ck(ready_busy_pin_n, 1'b1);
  endtask
  task automatic s_perr;
    sector_protected <= 1'b1;
    wren();
    frm(PB, 32'h0000_0200, 4, 1);
    ck(seen[5], 1'b0);
    ck(status_one_volatile, 8'h41);
    cyc(30);
    ck(busy_flag, 1'b1);
    ck(ready_busy_pin_n, 1'b0);
    sector_protected <= 1'b0;
    clr();
  endtask
  task automatic s_unit(input logic m);
    multipass_disable <= m;
    wren();
    frm(PA, 32'h40, 3, 1);
    @(posedge clk);
    unit_reprogrammed <= 1'b1;
    @(posedge clk);
    unit_reprogrammed <= 1'b0;
    cyc(2);
    ck(program_error_flag, m);
    ck(seen[0], !m);
    ck(seen[1], m);
    if (!m) begin
      fin(1'b1);
      ck(status_one_volatile, 8'h41);
    end
    clr();
  endtask
  task automatic s_range;
    wren();
    frm(PB, ABYT, 4, 1);
    ck(status_one_volatile, 8'h41);
    clr();
    wren();
    frm(SB, ABYT, 4);
    ck(status_one_volatile, 8'h21);
    clr();
  endtask
  task automatic s_erase;
    wren();
    frm(SA, 32'h8000, 3);
    ck(seen[3], 1'b1);
    ck(target_addr, 32'h8000);
    fin(1'b0);
    ck(status_one_volatile, 8'h00);
    sector_protected <= 1'b1;
    wren();
    frm(SB, 32'h8000, 4);
    ck(seen[3], 1'b0);
    ck(status_one_volatile, 8'h21);
    sector_protected <= 1'b0;
    clr();
  endtask
  task automatic s_chip;
    wren();
    for (int b = 1; b < 8; b++) begin
      block_protect <= 3'(b);
      frm(CH);
      ck(seen[2], 1'b0);
      ck(status_one_volatile, 8'h02);
    end
    block_protect <= 3'h0;
    frm(CH);
    ck(seen[2], 1'b1);
    fin(1'b0);
    ck(status_one_volatile, 8'h00);
  endtask
  task automatic s_otp;
    otp_locked <= 1'b1;
    wren();
    frm(OT, 32'h0, 4, 4);
    ck(seen[4], 1'b0);
    ck(status_one_volatile, 8'h41);
    clr();
    wren();
    frm(OT, 32'h4, 4, 4, 8'hff);
    ck({seen[4], program_error_flag}, 2'b10);
    fin(1'b0);
    otp_locked <= 1'b0;
    wren();
    frm(OT, 32'h8, 4, 4);
    ck({seen[4], program_error_flag}, 2'b10);
    fin(1'b0);
  endtask
  task automatic s_eval(input logic e, input logic [31:0] a);
    sector_erased <= e;
    frm(EV, a, 4);
    ck(busy_flag, 1'b1);
    for (int i = 0; i < 40 && busy_flag !== 1'b0; i++) cyc(1);
    ck(status_two_volatile, {5'h00, e, 2'b00});
    ck(status_one_volatile, 8'h00);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    summarize();
  end
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    ck(status_one_volatile, 8'h00);
    ck(ready_busy_pin_n, 1'b1);
    s_nowel();
    s_prog(PA, 3, 1'b0, 1'b0, 9'h0fe);
    s_prog(PB, 4, 1'b0, 1'b1, 9'h1fe);
    s_prog(PC, 3, 1'b1, 1'b1, 9'h1fe);
    s_prog(PD, 4, 1'b1, 1'b0, 9'h1fe);
    s_perr();
    s_unit(1'b1);
    s_unit(1'b0);
    s_range();
    s_erase();
    s_chip();
    s_otp();
    s_eval(1'b1, 32'h8000);
    s_eval(1'b0, ABYT);
    summarize();
  end
endmodule // spi_flash_program_erase_sequencer_tb
